// ===== logic/adcsq_pkg.sv
/*
 adcsq_pkg: constants, register offsets and field positions of the
 sequential conversion request source.
 assumes: one 125 MHz clock, plain register port with 16-bit data.
*/
// What this block does
// - slot 2 source queues up to four requests
// - slot 0 source holds exactly one request
// - fifo queue plus separate backup stage
// - slot 2 three middle stages, slot 0 none
// - queue input only fills stages, flush only
// - refill entry re-enters queue on start
// - all-refill sequence repeats forever
// - head stage gives the requested channel
// - per-entry bit: wait trigger or immediate
// - per-entry bit enables completion interrupt
// - start empties head, next entry advances
// - aborted request saved into backup stage
// - valid backup requested before head entry
// - request arbiter while valid entry held
// - trigger event releases head-stage request
// - event flag: trigger edge or software write
// - event clears on start or clear commands
// - writes to full queue silently dropped
// - clear-next hits backup first, else head
// - gating blocks requests, keeps queue intact
// - software trigger needs valid head or backup
package adcsq_pkg;
	// register indices on the plain port
	localparam logic [3:0] ADDR_QIN = 4'h0;
	localparam logic [3:0] ADDR_QCTL = 4'h1;
	localparam logic [3:0] ADDR_HEAD = 4'h2;
	localparam logic [3:0] ADDR_BACKUP = 4'h3;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	// entry layout, shared by input, head and backup
	localparam int CHAN_W = 4;
	localparam int ENTRY_W = 7;
	localparam int F_REFILL = 4;
	localparam int F_TRIG = 5;
	localparam int F_IRQEN = 6;
	localparam int F_VALID = 8;
	// control register fields
	localparam int F_GATE_LO = 0;
	localparam int F_EXTTR = 2;
	localparam int F_CLEAR_NEXT = 8;
	localparam int F_SW_TRIGGER = 9;
	localparam int F_FLUSH = 10;
	localparam int F_CLEAR_EVENT = 11;
	// status register fields
	localparam int F_EMPTY = 0;
	localparam int F_FULL = 1;
	localparam int F_EVENT = 2;
	localparam int F_GATE_LVL = 3;
	localparam int F_BUSY = 4;
	// gate mode codes
	localparam logic [1:0] GATE_OFF = 2'h0;
	localparam logic [1:0] GATE_ON = 2'h1;
	localparam logic [1:0] GATE_HIGH = 2'h2;
	localparam logic [1:0] GATE_LOW = 2'h3;
	localparam logic [15:0] RST_CTL = 16'h0000;
	// handling states
	typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_CONV} adcsq_state_e;
endpackage

// ===== logic/adcsq_sync.sv
/*
 adcsq_sync: two flip-flop synchroniser for pin levels.
 assumes: input is asynchronous to CLK.
*/
`timescale 1ns/100ps
module adcsq_sync (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// level in and out
	input wire logic D,
	output logic Q
);
	logic meta; // first stage, read only by q
	// two stages, only the second looks at the first
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			meta <= 1'b0;
			Q <= 1'b0;
		end else begin
			meta <= D;
			Q <= meta;
		end
	end
endmodule // adcsq_sync

// ===== logic/adcsq_queue.sv
/*
 adcsq_queue: the fifo of request entries, head at index 0.
 assumes: push and pop are one-cycle pulses from the same clock.
*/
`timescale 1ns/100ps
module adcsq_queue #(
	parameter int DEPTH = 4,
	parameter int W = 7
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// control
	input wire logic push,
	input wire logic [W-1:0] push_data,
	input wire logic pop,
	input wire logic flush,
	input wire logic clr_head,
	// status
	output logic [W-1:0] head,
	output logic head_valid,
	output logic full
);
	logic [W-1:0] stage [DEPTH]; // stage 0 is the head
	logic [DEPTH-1:0] valid; // valid bits, packed toward head
	logic drop; // head leaves this cycle
	logic [DEPTH-1:0] shifted; // valid after drop
	logic [DEPTH-1:0] next_valid;
	logic [DEPTH:0] below_full; // stage below holds an entry, head has none below
	logic [DEPTH-1:0] take; // one-hot stage that takes the pushed entry
	assign drop = (pop | clr_head) & valid[0];
	assign shifted = drop ? (valid >> 1) : valid;
	assign head = stage[0];
	assign head_valid = valid[0];
	assign full = &valid;
	// first empty slot after the shift takes the pushed entry
	assign below_full = {shifted, 1'b1};
	assign take = push ? (~shifted & below_full[DEPTH-1:0]) : '0;
	// flush wins over a push in the same cycle
	assign next_valid = flush ? '0 : (shifted | take);
	// valid bits
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			valid <= '0;
		end else begin
			valid <= next_valid;
		end
	end
	// data shift, no reset needed on payload
	always_ff @(posedge CLK) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (take[i]) begin
				stage[i] <= push_data;
			end else if (drop && i < DEPTH - 1) begin
				// modulo keeps the index in range when the loop unrolls
				stage[i] <= stage[(i + 1) % DEPTH];
			end
		end
	end
endmodule // adcsq_queue

// ===== logic/adcsq_source.sv
/*
 adcsq_source: sequential conversion request source, one queue with
 backup stage, trigger and gate handling, and register port.
 assumes: arbiter pulses start, abort and done for our request only;
 trigger and gate pins are asynchronous and synchronised here.
*/
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module adcsq_source
	import adcsq_pkg::*;
#(
	parameter int DEPTH = 4 // 4 for slot 2, 1 for slot 0
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// register port
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	// external pins
	input wire logic SELECTED_TRIGGER_INPUT,
	input wire logic SELECTED_GATE_INPUT,
	// arbiter side
	output logic REQ,
	output logic [adcsq_pkg::CHAN_W-1:0] REQ_CHAN,
	input wire logic CONV_START,
	input wire logic CONV_ABORT,
	input wire logic CONV_DONE,
	output logic SOURCE_EVENT
);
	import adcsq_pkg::*;

	// synchronised pins
	logic trig_s; // trigger level after two stages
	logic gate_s; // gate level after two stages
	logic trig_d; // previous trigger level for edge

	// control and state
	logic [1:0] gate_mode_select; // gating mode
	logic external_trigger_enable; // hardware edges count
	logic trigger_event_flag; // sticky trigger seen
	logic [ENTRY_W-1:0] backup; // aborted entry
	logic backup_valid; // backup holds a request
	logic [ENTRY_W-1:0] active; // entry in conversion
	logic active_from_backup; // conversion restarted from backup
	adcsq_state_e state; // idle or converting

	// decoded writes
	wire wr_qin = WR && ADDR == ADDR_QIN;
	wire wr_ctl = WR && ADDR == ADDR_QCTL;
	wire clear_next_entry_command = wr_ctl && WDATA[F_CLEAR_NEXT];
	wire software_trigger = wr_ctl && WDATA[F_SW_TRIGGER];
	wire cmd_flush = wr_ctl && WDATA[F_FLUSH];
	wire clear_event_command = wr_ctl && WDATA[F_CLEAR_EVENT];

	// queue view
	logic [ENTRY_W-1:0] head; // head stage entry
	logic head_valid; // head holds an entry
	logic full; // all stages valid

	// next request candidate: backup goes first
	wire [ENTRY_W-1:0] cand = backup_valid ? backup : head;
	wire cand_valid = backup_valid | head_valid;

	// gate decode, queue untouched either way
	wire gate_open = gate_mode_select == GATE_ON
		|| (gate_mode_select == GATE_HIGH && gate_s)
		|| (gate_mode_select == GATE_LOW && !gate_s);

	// trigger edge and software trigger
	wire hw_edge = external_trigger_enable && trig_s && !trig_d;
	wire sw_trig = software_trigger && cand_valid;

	// request wanted: immediate entries or waiting with event seen
	wire released = !cand[F_TRIG] || trigger_event_flag;
	wire req_now = state == ADCSQ_IDLE && cand_valid && gate_open && released;

	// start takes head only when backup did not win
	wire start = CONV_START && req_now;
	wire pop_head = start && !backup_valid;
	// refill: started head entry goes back to the input
	wire refill = pop_head && head[F_REFILL];
	// software writes dropped when full
	wire push = refill || (wr_qin && !full);
	wire [ENTRY_W-1:0] push_data = refill ? head : WDATA[ENTRY_W-1:0];
	// clear-next: backup first, head otherwise
	wire clr_head = clear_next_entry_command && !backup_valid;

	assign REQ = req_now;
	assign REQ_CHAN = cand[CHAN_W-1:0];

	// pin synchronisers
	adcsq_sync u_sync_trig (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.D(SELECTED_TRIGGER_INPUT),
		.Q(trig_s)
	);
	adcsq_sync u_sync_gate (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.D(SELECTED_GATE_INPUT),
		.Q(gate_s)
	);

	// queue: depth 4 for slot 2, depth 1 for slot 0
	adcsq_queue #(
		.DEPTH(DEPTH),
		.W(ENTRY_W)
	) u_queue (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.push(push),
		.push_data(push_data),
		.pop(pop_head),
		.flush(cmd_flush),
		.clr_head(clr_head),
		.head(head),
		.head_valid(head_valid),
		.full(full)
	);

	// control register, commands are write-only pulses
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			gate_mode_select <= RST_CTL[F_GATE_LO +: 2];
			external_trigger_enable <= RST_CTL[F_EXTTR];
		end else if (wr_ctl) begin
			gate_mode_select <= WDATA[F_GATE_LO +: 2];
			external_trigger_enable <= WDATA[F_EXTTR];
		end
	end

	// trigger edge memory
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			trig_d <= 1'b0;
		end else begin
			trig_d <= trig_s;
		end
	end

	// event flag: set wins over every clear
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			trigger_event_flag <= 1'b0;
		end else if (hw_edge || sw_trig) begin
			trigger_event_flag <= 1'b1;
		end else if (start || clear_event_command || cmd_flush
			|| clear_next_entry_command) begin
			trigger_event_flag <= 1'b0;
		end
	end

	// backup stage: abort saves, restart or clear empties it
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			backup_valid <= 1'b0;
			backup <= '0;
		end else if (state == ADCSQ_CONV && CONV_ABORT) begin
			backup_valid <= 1'b1;
			backup <= active;
		end else if ((start && backup_valid) || clear_next_entry_command || cmd_flush) begin
			backup_valid <= 1'b0;
		end
	end

	// conversion tracking; abort or done ends it
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state <= ADCSQ_IDLE;
			active <= '0;
			active_from_backup <= 1'b0;
		end else begin
			case (state)
				ADCSQ_IDLE: begin
					if (start) begin
						state <= ADCSQ_CONV;
						active <= cand;
						active_from_backup <= backup_valid;
					end
				end
				ADCSQ_CONV: begin
					if (CONV_ABORT || CONV_DONE) begin
						state <= ADCSQ_IDLE;
					end
				end
				default: begin
					state <= ADCSQ_IDLE;
				end
			endcase
		end
	end

	// completion event gated by the entry's own enable
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SOURCE_EVENT <= 1'b0;
		end else begin
			SOURCE_EVENT <= state == ADCSQ_CONV && CONV_DONE && !CONV_ABORT
				&& active[F_IRQEN];
		end
	end

	// read mux; unmapped reads return zero
	logic [15:0] next_rdata;
	always_comb begin
		next_rdata = 16'h0000;
		case (ADDR)
			ADDR_QCTL: begin
				next_rdata[F_GATE_LO +: 2] = gate_mode_select;
				next_rdata[F_EXTTR] = external_trigger_enable;
			end
			ADDR_HEAD: begin
				next_rdata[ENTRY_W-1:0] = head;
				next_rdata[F_VALID] = head_valid;
			end
			ADDR_BACKUP: begin
				next_rdata[ENTRY_W-1:0] = backup;
				next_rdata[F_VALID] = backup_valid;
			end
			ADDR_STAT: begin
				next_rdata[F_EMPTY] = !head_valid;
				next_rdata[F_FULL] = full;
				next_rdata[F_EVENT] = trigger_event_flag;
				next_rdata[F_GATE_LVL] = gate_s;
				next_rdata[F_BUSY] = state == ADCSQ_CONV;
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	// read data stand one cycle after the strobe
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RDATA <= 16'h0000;
		end else if (RD) begin
			RDATA <= next_rdata;
		end else begin
			RDATA <= 16'h0000;
		end
	end

	// a started request came from backup when one was held
	a_backup_first: assert property (@(posedge CLK) disable iff (!RESET_N)
		start && backup_valid |=> !backup_valid && active == $past(backup))
		else $error("backup entry not started first");

	// abort stores the running entry
	a_abort_saves: assert property (@(posedge CLK) disable iff (!RESET_N)
		state == ADCSQ_CONV && CONV_ABORT |=> backup_valid && backup == $past(active))
		else $error("aborted entry not saved");

	// no request while gate closed
	a_gate_blocks: assert property (@(posedge CLK) disable iff (!RESET_N)
		!gate_open |-> !REQ)
		else $error("request while gated");

	// trigger-wait entry needs event
	a_trig_wait: assert property (@(posedge CLK) disable iff (!RESET_N)
		REQ && cand[F_TRIG] |-> trigger_event_flag)
		else $error("triggered entry requested without event");

	// start clears the event unless a new one arrives
	a_event_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
		start && !hw_edge && !sw_trig |=> !trigger_event_flag)
		else $error("event not cleared on start");

	// hardware edge sets event
	sequence s_edge;
		external_trigger_enable && trig_s && !trig_d;
	endsequence
	a_edge_sets: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_edge |=> trigger_event_flag)
		else $error("trigger edge lost");

	// full queue ignores software write
	a_full_drop: assert property (@(posedge CLK) disable iff (!RESET_N)
		wr_qin && full && !pop_head && !clr_head && !cmd_flush |=> full && head == $past(head))
		else $error("write into full queue changed it");

	// refilled entry keeps the queue non-empty
	a_refill_keeps: assert property (@(posedge CLK) disable iff (!RESET_N)
		refill && !cmd_flush |=> head_valid)
		else $error("refill entry lost");

	// done with interrupt enable pulses the event one cycle later
	a_done_event: assert property (@(posedge CLK) disable iff (!RESET_N)
		state == ADCSQ_CONV && CONV_DONE && !CONV_ABORT && active[F_IRQEN] |=> SOURCE_EVENT)
		else $error("source event missing");

	// a grant moves the source into conversion and drops the request
	sequence s_granted;
		start;
	endsequence
	sequence s_converting;
		state == ADCSQ_CONV && !REQ;
	endsequence
	a_start_busy: assert property (@(posedge CLK) disable iff (!RESET_N)
		s_granted |=> s_converting)
		else $error("start did not enter conversion");

	// restart from backup is marked in active_from_backup
	a_backup_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
		start && backup_valid |=> active_from_backup)
		else $error("backup restart not marked");

	// a pop without a push frees at least one stage
	a_head_advance: assert property (@(posedge CLK) disable iff (!RESET_N)
		pop_head && !push |=> !full)
		else $error("head did not advance");

	// flush empties queue and backup unless an abort lands at once
	a_flush_empties: assert property (@(posedge CLK) disable iff (!RESET_N)
		cmd_flush && !(state == ADCSQ_CONV && CONV_ABORT)
			|=> !head_valid && !backup_valid)
		else $error("flush left an entry");

	// clear-next takes the backup and leaves the head alone
	a_clear_backup: assert property (@(posedge CLK) disable iff (!RESET_N)
		clear_next_entry_command && backup_valid && !CONV_ABORT && !cmd_flush
			|=> !backup_valid && head_valid == $past(head_valid))
		else $error("clear-next missed the backup");

	// clear commands drop the event unless a new one arrives
	a_event_cmd_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
		(clear_event_command || cmd_flush || clear_next_entry_command)
			&& !hw_edge && !sw_trig |=> !trigger_event_flag)
		else $error("event survived a clear command");

	// software trigger with a valid entry sets the event
	a_sw_trig_sets: assert property (@(posedge CLK) disable iff (!RESET_N)
		software_trigger && cand_valid |=> trigger_event_flag)
		else $error("software trigger lost");

	// software trigger with nothing queued leaves the event clear
	a_sw_trig_empty: assert property (@(posedge CLK) disable iff (!RESET_N)
		software_trigger && !cand_valid && !hw_edge && !trigger_event_flag
			|=> !trigger_event_flag)
		else $error("software trigger on empty source");

	// a closed gate leaves queue contents untouched; payload only counts when valid
	a_gate_keeps: assert property (@(posedge CLK) disable iff (!RESET_N)
		!gate_open && !push && !cmd_flush && !clr_head
			|=> head_valid == $past(head_valid) && (!head_valid || head == $past(head)))
		else $error("gated queue changed");

	// an aborted conversion raises no completion event
	a_abort_quiet: assert property (@(posedge CLK) disable iff (!RESET_N)
		state == ADCSQ_CONV && CONV_ABORT |=> !SOURCE_EVENT)
		else $error("event after abort");

	// done or abort returns the source to idle
	a_conv_idle: assert property (@(posedge CLK) disable iff (!RESET_N)
		state == ADCSQ_CONV && (CONV_ABORT || CONV_DONE) |=> state == ADCSQ_IDLE)
		else $error("conversion did not end");
endmodule // adcsq_source

// ===== verif/adcsq_arbiter_model.sv
/*
 adcsq_arbiter_model: behavioural arbiter serving one sequential source.
 assumes: REQ is a level held until a start is taken; LAT is at least 2.
*/
`timescale 1ns/100ps
module adcsq_arbiter_model (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// bench control
	input wire logic ABORT_NEXT,
	input wire logic [3:0] LAT,
	// source side
	input wire logic REQ,
	output logic CONV_START,
	output logic CONV_ABORT,
	output logic CONV_DONE
);
	logic busy; // a conversion is running
	logic [3:0] cnt; // cycles left in the running conversion
	// grant, run for LAT+1 cycles, then finish or abort
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			CONV_START <= 1'b0;
			CONV_ABORT <= 1'b0;
			CONV_DONE <= 1'b0;
		end else begin
			CONV_START <= 1'b0;
			CONV_ABORT <= 1'b0;
			CONV_DONE <= 1'b0;
			if (CONV_START) begin
				// a grant only counts if the request still stood
				busy <= REQ;
				cnt <= LAT;
			end else if (busy) begin
				if (cnt == 4'h0) begin
					busy <= 1'b0;
					CONV_ABORT <= ABORT_NEXT;
					CONV_DONE <= !ABORT_NEXT;
				end else
					cnt <= cnt - 4'h1;
			end else if (REQ) begin
				CONV_START <= 1'b1;
			end
		end
	end
endmodule // adcsq_arbiter_model

// ===== verif/adcsq_source_tb_top.sv
/*
 adcsq_source_tb_top: self-checking bench for the 4-stage source.
 assumes: arbiter model answers every request; pins driven by the bench.
*/
`timescale 1ns/100ps
module adcsq_source_tb_top;
	import adcsq_pkg::*;
	logic CLK, RESET_N; // clock and reset
	logic [3:0] addr, req_chan, lat;
	logic [15:0] wdata, rdata, rv;
	logic wr, rd, trig_pin, gate_pin, req, conv_start, conv_abort, conv_done;
	logic source_event, abort_next;
	int fails, samples_checked, seed, events_seen;
	logic [3:0] starts[$]; // channels granted, in order
	logic [6:0] e[5]; // entries written this scenario
	adcsq_source #(.DEPTH(4)) adcsq_source_i (.CLK(CLK), .RESET_N(RESET_N), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SELECTED_TRIGGER_INPUT(trig_pin),
		.SELECTED_GATE_INPUT(gate_pin), .REQ(req), .REQ_CHAN(req_chan),
		.CONV_START(conv_start), .CONV_ABORT(conv_abort), .CONV_DONE(conv_done),
		.SOURCE_EVENT(source_event));
	adcsq_arbiter_model adcsq_arbiter_model_i (.CLK(CLK), .RESET_N(RESET_N),
		.ABORT_NEXT(abort_next), .LAT(lat), .REQ(req), .CONV_START(conv_start),
		.CONV_ABORT(conv_abort), .CONV_DONE(conv_done));
	// clock, 8 ns period
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	// mid-cycle sampling, since REQ and REQ_CHAN are combinational
	always @(negedge CLK) begin
		if (conv_start && req)
			starts.push_back(req_chan);
		if (source_event)
			events_seen++;
	end
	function automatic logic [3:0] rnd4();
		rnd4 = 4'($random(seed));
	endfunction
	function automatic logic [6:0] ent(logic [3:0] ch, logic rf, logic tr, logic ie);
		ent = {ie, tr, rf, ch};
	endfunction
	// head view: entry plus valid bit
	function automatic logic [15:0] hd(logic [6:0] x);
		hd = {7'h0, 1'b1, 1'b0, x};
	endfunction
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge CLK);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge CLK);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge CLK);
		addr <= a;
		rd <= 1'b1;
		@(posedge CLK);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// bounded wait for n grants; running out ends the run
	task automatic wait_starts(input int n);
		int k;
		for (k = 0; k < 2000 && starts.size() < n; k++)
			@(posedge CLK);
		if (starts.size() < n) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, starts.size(), n);
			give_verdict();
		end
	endtask
	task automatic push(input logic [6:0] x);
		wr_reg(ADDR_QIN, {9'h0, x});
	endtask
	task automatic idle;
		repeat (20) @(posedge CLK);
	endtask
	initial begin
		seed = 41388;
		fails = 0;
		samples_checked = 0;
		events_seen = 0;
		RESET_N = 1'b0;
		{addr, wdata, wr, rd, trig_pin, gate_pin, abort_next} = '0;
		lat = 4'h3;
		repeat (10) @(posedge CLK);
		RESET_N <= 1'b1;
		rd_reg(ADDR_STAT, rv);
		chk(rv, 16'h0001);
		// fill past capacity, gate closed, then open
		lat <= (rnd4() & 4'h7) + 4'h2;
		for (int i = 0; i < 5; i++) begin
			e[i] = ent(rnd4(), 1'b0, 1'b0, 1'b1);
			push(e[i]);
		end
		rd_reg(ADDR_STAT, rv);
		chk(rv, 16'h0002);
		rd_reg(ADDR_HEAD, rv);
		chk(rv, hd(e[0]));
		wr_reg(ADDR_QCTL, {14'h0, GATE_ON});
		wait_starts(4);
		idle();
		for (int i = 0; i < 4; i++)
			chk({12'h0, starts[i]}, {12'h0, e[i][3:0]});
		chk(16'(starts.size()), 16'h0004);
		chk(16'(events_seen), 16'h0004);
		rd_reg(ADDR_STAT, rv);
		chk(rv, 16'h0001);
		// abort of the first conversion: it is granted again first
		wr_reg(ADDR_QCTL, 16'h0);
		starts.delete();
		for (int i = 0; i < 2; i++) begin
			e[i] = ent(rnd4(), 1'b0, 1'b0, 1'b0);
			push(e[i]);
		end
		abort_next <= 1'b1;
		wr_reg(ADDR_QCTL, {14'h0, GATE_ON});
		for (int k = 0; k < 100 && !conv_abort; k++)
			@(posedge CLK);
		chk(16'(conv_abort), 16'h0001);
		abort_next <= 1'b0;
		wait_starts(3);
		chk({12'h0, starts[1]}, {12'h0, e[0][3:0]});
		chk({12'h0, starts[2]}, {12'h0, e[1][3:0]});
		idle();
		// all-refill pair repeats without software writes
		wr_reg(ADDR_QCTL, 16'h0);
		starts.delete();
		for (int i = 0; i < 2; i++) begin
			e[i] = ent(rnd4(), 1'b1, 1'b0, 1'b0);
			push(e[i]);
		end
		wr_reg(ADDR_QCTL, {14'h0, GATE_ON});
		wait_starts(6);
		wr_reg(ADDR_QCTL, 16'h0);
		for (int i = 0; i < 6; i++)
			chk({12'h0, starts[i]}, {12'h0, e[i % 2][3:0]});
		idle();
		wr_reg(ADDR_QCTL, 16'h1 << F_FLUSH);
		rd_reg(ADDR_STAT, rv);
		chk(rv, 16'h0001);
		// software trigger on an empty queue starts nothing
		starts.delete();
		wr_reg(ADDR_QCTL, {14'h0, GATE_ON} | (16'h1 << F_SW_TRIGGER));
		idle();
		chk(16'(starts.size()), 16'h0000);
		rd_reg(ADDR_STAT, rv);
		chk(rv, 16'h0001);
		wr_reg(ADDR_QCTL, 16'h1 << F_CLEAR_EVENT);
		e[0] = ent(rnd4(), 1'b0, 1'b1, 1'b0);
		push(e[0]);
		wr_reg(ADDR_QCTL, 16'h1 << F_SW_TRIGGER);
		rd_reg(ADDR_STAT, rv);
		chk(rv, 16'h0004);
		wr_reg(ADDR_QCTL, 16'h1 << F_CLEAR_EVENT);
		rd_reg(ADDR_STAT, rv);
		chk(rv, 16'h0000);
		wr_reg(ADDR_QCTL, {14'h0, GATE_ON});
		repeat (10) @(posedge CLK);
		chk(16'(req), 16'h0000);
		wr_reg(ADDR_QCTL, {14'h0, GATE_ON} | (16'h1 << F_SW_TRIGGER));
		wait_starts(1);
		chk({12'h0, starts[0]}, {12'h0, e[0][3:0]});
		idle();
		rd_reg(ADDR_STAT, rv);
		chk(rv, 16'h0001);
		// external trigger edge
		e[1] = ent(rnd4(), 1'b0, 1'b1, 1'b0);
		push(e[1]);
		wr_reg(ADDR_QCTL, {14'h0, GATE_ON} | (16'h1 << F_EXTTR));
		repeat (5) @(posedge CLK);
		trig_pin <= 1'b1;
		wait_starts(2);
		chk({12'h0, starts[1]}, {12'h0, e[1][3:0]});
		trig_pin <= 1'b0;
		idle();
		// gate held shut, then opened, in both polarities
		for (int m = 2; m < 4; m++) begin
			starts.delete();
			gate_pin <= (m == 3);
			wr_reg(ADDR_QCTL, {14'h0, 2'(m)});
			e[0] = ent(rnd4(), 1'b0, 1'b0, 1'b0);
			push(e[0]);
			repeat (10) @(posedge CLK);
			chk(16'(req), 16'h0000);
			rd_reg(ADDR_HEAD, rv);
			chk(rv, hd(e[0]));
			gate_pin <= (m != 3);
			wait_starts(1);
			chk({12'h0, starts[0]}, {12'h0, e[0][3:0]});
			idle();
		end
		// abort a triggered entry; clear-next takes backup first, then head
		wr_reg(ADDR_QCTL, 16'h0);
		gate_pin <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			e[i] = ent(rnd4(), 1'b0, 1'b1, 1'b0);
			push(e[i]);
		end
		abort_next <= 1'b1;
		wr_reg(ADDR_QCTL, {14'h0, GATE_ON} | (16'h1 << F_SW_TRIGGER));
		for (int k = 0; k < 100 && !conv_abort; k++)
			@(posedge CLK);
		chk(16'(conv_abort), 16'h0001);
		abort_next <= 1'b0;
		rd_reg(ADDR_BACKUP, rv);
		chk(rv, hd(e[0]));
		wr_reg(ADDR_QCTL, 16'h1 << F_CLEAR_NEXT);
		rd_reg(ADDR_BACKUP, rv);
		chk(rv, {9'h0, e[0]});
		rd_reg(ADDR_HEAD, rv);
		chk(rv, hd(e[1]));
		wr_reg(ADDR_QCTL, 16'h1 << F_CLEAR_NEXT);
		rd_reg(ADDR_STAT, rv);
		chk(rv, 16'h0009);
		chk(16'(events_seen), 16'h0004);
		give_verdict();
	end
endmodule // adcsq_source_tb_top
